/* File: rtl/ptptc_pkg.sv */
// Package for the trigger/timestamp control block.
// Assumes a single hclk domain and a 32-bit AHB-Lite register bus.
package ptptc_pkg;
  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL     = 12'h052c;
  localparam logic [11:0] ADDR_TGT_NS   = 12'h0530;
  localparam logic [11:0] ADDR_TGT_SEC  = 12'h0534;
  localparam logic [11:0] ADDR_INDEX    = 12'h0540;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h0544;
  localparam logic [11:0] ADDR_IRQ_CLR  = 12'h0548;
  localparam logic [11:0] ADDR_IRQ_EN   = 12'h054c;
  localparam logic [11:0] ADDR_CASCADE  = 12'h0550;
  // Control/status field positions
  localparam int CTRL_OUT_SEL = 8;
  localparam int CTRL_PIN_IN  = 7;
  localparam int CTRL_PIN_DIR = 6;
  localparam int CTRL_TS_IEN  = 5;
  localparam int CTRL_TRG_ACT = 4;
  localparam int CTRL_TRG_EN  = 3;
  localparam int CTRL_TRG_RST = 2;
  localparam int CTRL_TS_EN   = 1;
  localparam int CTRL_TS_RST  = 0;
  // Index register fields
  localparam int IDX_TS_BIT   = 8;
  // Interrupt status layout: [1:0] stamp units, [4:2] trigger done
  localparam int IRQ_TRG_LSB  = 2;
  // Cascade register: [2:0] member, [5:3] tail
  localparam int CAS_TAIL_LSB = 3;
  // Widths and reset values
  localparam int NS_W         = 30;
  localparam int CNT_W        = 8;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
endpackage : ptptc_pkg

/* File: rtl/ptptc_unit_if.sv */
// Interface carrying per-unit enables and targets from the register decoder to the units, and fire pulses back.
// Assumes the same hclk domain on both sides.
`timescale 1ns/1ps
interface ptptc_unit_if #(parameter int NT = 3);
  logic [NT-1:0] fire;     // Trigger unit reached its target
  logic [NT-1:0] en;       // Trigger unit enabled
  logic [31:0]   cur_sec;
  logic [29:0]   cur_ns;
  logic [NT*62-1:0] tgt;   // {sec,ns} per unit
  modport ctrl (input fire, output en, output tgt, output cur_sec,
                output cur_ns);
  modport cmp  (output fire, input en, input tgt, input cur_sec,
                input cur_ns);
endinterface : ptptc_unit_if

/* File: rtl/ptptc_cmp.sv */
// Target-time comparators, one per trigger unit.
// Assumes the time inputs are registered in the hclk domain.
`timescale 1ns/1ps
module ptptc_cmp #(
  parameter int NT = 3
) (
  // Shared unit signals
  ptptc_unit_if.cmp u
);
  // Fire once the running time is at or past the target
  always_comb begin
    for (int i = 0; i < NT; i++) begin
      u.fire[i] = u.en[i] &&
        ({u.cur_sec, u.cur_ns} >= u.tgt[i*62 +: 62]);
    end
  end
endmodule : ptptc_cmp

/* File: rtl/ptptc_top.sv */
// Trigger output and timestamp input control with AHB-Lite registers.
// Assumes a free-running precision time on ptp_sec/ptp_ns in hclk domain,
// an asynchronous event pin, and a single AHB-Lite master.
//
// Summary of operation
// - Index register selects trigger and stamp unit
// - Out-select 1 combinational pin, 0 flopped
// - Pin monitor reads pin level after two sync flops
// - Direction 1 stamp input, 0 trigger output
// - Stamp interrupt enable gates indexed unit
// - Active flag high while trigger armed
// - Trigger enable set, self-clears on firing
// - Trigger soft reset idles unit, zeroes its target
// - Stamp enable one clears event counter
// - Stamp enable zero clears ready, overflow
// - Stamp soft reset returns unit to idle
// - Thirty-bit nanosecond target, top bits zero
// - Thirty-two-bit second target per unit
// - Write-clear stamp interrupt bits per unit
// - No tail in cascade loops forever when unit 0 is a member
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module ptptc_top
  import ptptc_pkg::*;
#(
  parameter int NT = 3,
  parameter int NS = 2
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Precision time
  input  wire logic [31:0] ptp_sec,
  input  wire logic [29:0] ptp_ns,
  // Event pin
  input  wire logic        event_pin_in,
  output logic             event_pin_out,
  output logic             event_pin_oen_n,
  // Interrupt
  output logic             irq
);
  import ptptc_pkg::*;

  // Elaboration check: index widths are fixed at 2 and 1 bits
  if (NT < 1 || NT > 4 || NS < 1 || NS > 2) begin : g_bad
    $error("ptptc_top: unit counts out of range");
  end

  typedef enum logic [1:0] {
    PTPTC_IDLE = 2'b01,
    PTPTC_DATA = 2'b10
  } ptptc_phase_t;

  ptptc_phase_t     phase_q;
  logic             wr_q;
  logic [11:0]      addr_q;
  logic [1:0]       trg_idx_q;
  logic             ts_idx_q;
  logic             out_sel_q, pin_dir_q;
  logic [NS-1:0]    ts_ien_q, ts_en_q, stamp_ready_flag_q, ts_ovf_q;
  logic [NS*CNT_W-1:0] ts_cnt_q;
  logic [NT-1:0]    trg_en_q, trg_act_q;
  logic [NT-1:0]    cas_mem_q, cas_tail_q;
  logic [NT*62-1:0] tgt_q;
  logic [NS+NT-1:0] irq_stat_q, irq_en_q;
  logic [31:0]      sec_q;
  logic [29:0]      ns_q;
  logic [1:0]       pin_sync_q;
  logic             pin_prev_q, trg_pulse_q, pin_flop_q;
  logic [NT-1:0]    fire;
  logic             wr_go;
  logic [NS-1:0]    ts_evt;
  logic [3:0]       trg_sel;
  logic [NS+NT-1:0] irq_set;

  ptptc_unit_if #(.NT(NT)) uif ();
  assign uif.en      = trg_en_q;
  assign uif.tgt     = tgt_q;
  assign uif.cur_sec = sec_q;
  assign uif.cur_ns  = ns_q;
  assign fire        = uif.fire;

  ptptc_cmp #(.NT(NT)) u_cmp (
    .u (uif.cmp)
  );

  // Index helper: one-hot mask of the selected unit
  function automatic logic [3:0] sel_mask(input logic [1:0] idx);
    sel_mask = 4'h1 << idx;
  endfunction : sel_mask

  // Selected trigger unit as a mask; its low NT bits are empty when the index is out of range
  assign trg_sel = sel_mask(trg_idx_q);

  // AHB-Lite address phase capture; zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= PTPTC_IDLE;
      wr_q    <= 1'b0;
      addr_q  <= 12'h000;
    end else if (hready && hsel && htrans == HTRANS_NONSEQ) begin
      phase_q <= PTPTC_DATA;
      wr_q    <= hwrite;
      addr_q  <= haddr[11:0];
    end else if (hready) begin
      phase_q <= PTPTC_IDLE;
      wr_q    <= 1'b0;
    end
  end

  assign wr_go = (phase_q == PTPTC_DATA) && wr_q;

  // Time and pin sampling; pin passes two flops first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_q      <= ZERO32;
      ns_q       <= 30'h0000_0000;
      pin_sync_q <= 2'b00;
      pin_prev_q <= 1'b0;
    end else begin
      sec_q      <= ptp_sec;
      ns_q       <= ptp_ns;
      pin_sync_q <= {pin_sync_q[0], event_pin_in};
      pin_prev_q <= pin_sync_q[1];
    end
  end

  // Rising edge on the input pin is an event for every enabled unit in input mode
  always_comb begin
    for (int i = 0; i < NS; i++) begin
      ts_evt[i] = pin_dir_q && ts_en_q[i] &&
                  pin_sync_q[1] && !pin_prev_q;
    end
  end

  // Global configuration and index
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trg_idx_q  <= 2'b00;
      ts_idx_q   <= 1'b0;
      out_sel_q  <= 1'b0;
      pin_dir_q  <= 1'b0;
      cas_mem_q  <= '0;
      cas_tail_q <= '0;
      irq_en_q   <= '0;
    end else if (wr_go) begin
      case (addr_q)
        ADDR_INDEX: begin
          trg_idx_q <= hwdata[1:0];
          ts_idx_q  <= hwdata[IDX_TS_BIT];
        end
        ADDR_CTRL: begin
          out_sel_q <= hwdata[CTRL_OUT_SEL];
          pin_dir_q <= hwdata[CTRL_PIN_DIR];
        end
        ADDR_CASCADE: begin
          cas_mem_q  <= hwdata[NT-1:0];
          cas_tail_q <= hwdata[CAS_TAIL_LSB +: NT];
        end
        ADDR_IRQ_EN: irq_en_q <= hwdata[NS+NT-1:0];
        default: ;
      endcase
    end
  end

  // Trigger units: enable, active, targets, cascade chaining
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trg_en_q    <= '0;
      trg_act_q   <= '0;
      tgt_q       <= '0;
      trg_pulse_q <= 1'b0;
    end else begin
      trg_pulse_q <= |fire;
      for (int i = 0; i < NT; i++) begin
        if (fire[i]) begin
          trg_en_q[i]  <= 1'b0;
          trg_act_q[i] <= 1'b0;
          // Cascade: pass to unit i+1 if it is a member; no tail means wrap to unit 0
          if (cas_mem_q[i] && !cas_tail_q[i]) begin
            if (i + 1 < NT && cas_mem_q[(i + 1) % NT]) begin
              trg_en_q[(i + 1) % NT]  <= 1'b1;
              trg_act_q[(i + 1) % NT] <= 1'b1;
            end else if (cas_tail_q == '0) begin
              trg_en_q[0]  <= cas_mem_q[0];
              trg_act_q[0] <= cas_mem_q[0];
            end
          end
        end
      end
      if (wr_go && trg_sel[NT-1:0] != '0) begin
        case (addr_q)
          ADDR_CTRL: begin
            if (hwdata[CTRL_TRG_RST]) begin
              trg_en_q[trg_idx_q]  <= 1'b0;
              trg_act_q[trg_idx_q] <= 1'b0;
              tgt_q[trg_idx_q*62 +: 62] <= '0;
            end else begin
              trg_en_q[trg_idx_q]  <= hwdata[CTRL_TRG_EN];
              trg_act_q[trg_idx_q] <= hwdata[CTRL_TRG_EN];
            end
          end
          ADDR_TGT_NS:
            tgt_q[trg_idx_q*62 +: NS_W] <= hwdata[NS_W-1:0];
          ADDR_TGT_SEC:
            tgt_q[trg_idx_q*62+NS_W +: 32] <= hwdata;
          default: ;
        endcase
      end
    end
  end

  // Timestamp units: enable, counter, ready, overflow
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ts_en_q  <= '0;
      ts_ien_q <= '0;
      stamp_ready_flag_q <= '0;
      ts_ovf_q <= '0;
      ts_cnt_q <= '0;
    end else begin
      for (int i = 0; i < NS; i++) begin
        if (ts_evt[i]) begin
          stamp_ready_flag_q[i] <= 1'b1;
          if (&ts_cnt_q[i*CNT_W +: CNT_W]) ts_ovf_q[i] <= 1'b1;
          else ts_cnt_q[i*CNT_W +: CNT_W] <=
                 ts_cnt_q[i*CNT_W +: CNT_W] + CNT_W'(1);
        end
      end
      if (wr_go && addr_q == ADDR_CTRL && ts_idx_q < NS) begin
        ts_ien_q[ts_idx_q] <= hwdata[CTRL_TS_IEN];
        if (hwdata[CTRL_TS_RST]) begin
          ts_en_q[ts_idx_q]  <= 1'b0;
          ts_ien_q[ts_idx_q] <= 1'b0;
          stamp_ready_flag_q[ts_idx_q] <= 1'b0;
          ts_ovf_q[ts_idx_q] <= 1'b0;
          ts_cnt_q[ts_idx_q*CNT_W +: CNT_W] <= '0;
        end else if (hwdata[CTRL_TS_EN]) begin
          ts_en_q[ts_idx_q] <= 1'b1;
          ts_cnt_q[ts_idx_q*CNT_W +: CNT_W] <= '0;
        end else begin
          ts_en_q[ts_idx_q]  <= 1'b0;
          stamp_ready_flag_q[ts_idx_q] <= 1'b0;
          ts_ovf_q[ts_idx_q] <= 1'b0;
        end
      end
    end
  end

  // Status set sources: gated stamp events low, trigger done above
  assign irq_set = {fire, ts_evt & ts_ien_q};

  // Sticky interrupt status; a new event wins over a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= '0;
      irq       <= 1'b0;
    end else begin
      for (int i = 0; i < NS + NT; i++) begin
        if (irq_set[i])
          irq_stat_q[i] <= 1'b1;
        else if (wr_go && addr_q == ADDR_IRQ_CLR && hwdata[i])
          irq_stat_q[i] <= 1'b0;
      end
      irq <= |(irq_stat_q & irq_en_q);
    end
  end

  // Pin output: flopped copy or combinational path chosen by out-select
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_flop_q      <= 1'b0;
      event_pin_out   <= 1'b0;
      event_pin_oen_n <= 1'b1;
    end else begin
      pin_flop_q      <= trg_pulse_q;
      // Combinational source skips one stage, so it leads by a cycle
      event_pin_out   <= out_sel_q ? |fire : trg_pulse_q;
      event_pin_oen_n <= pin_dir_q;
    end
  end

  // Read data: answer in the data phase, zero wait
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= ZERO32;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= ZERO32;
      if (hready && hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
        case (haddr[11:0])
          ADDR_CTRL: begin
            hrdata[CTRL_OUT_SEL] <= out_sel_q;
            hrdata[CTRL_PIN_IN]  <= pin_sync_q[1];
            hrdata[CTRL_PIN_DIR] <= pin_dir_q;
            hrdata[CTRL_TS_IEN]  <= ts_ien_q[ts_idx_q];
            hrdata[CTRL_TRG_ACT] <= trg_act_q[trg_idx_q];
            hrdata[CTRL_TRG_EN]  <= trg_en_q[trg_idx_q];
            hrdata[CTRL_TS_EN]   <= ts_en_q[ts_idx_q];
          end
          ADDR_TGT_NS:
            hrdata[NS_W-1:0] <= tgt_q[trg_idx_q*62 +: NS_W];
          ADDR_TGT_SEC:
            hrdata <= tgt_q[trg_idx_q*62+NS_W +: 32];
          ADDR_INDEX: begin
            hrdata[1:0]        <= trg_idx_q;
            hrdata[IDX_TS_BIT] <= ts_idx_q;
          end
          ADDR_IRQ_STAT: hrdata[NS+NT-1:0] <= irq_stat_q;
          ADDR_IRQ_EN:   hrdata[NS+NT-1:0] <= irq_en_q;
          ADDR_CASCADE: begin
            hrdata[NT-1:0]            <= cas_mem_q;
            hrdata[CAS_TAIL_LSB +: NT] <= cas_tail_q;
          end
          default: ;
        endcase
      end
    end
  end

  // Software keeps only the cascade head enabled; hardware chains the rest
  logic unused_ok;
  assign unused_ok = pin_flop_q ^ hsize[0];
endmodule : ptptc_top

/* File: tb/ptptc_pin_model.sv */
// Far-side model of the event pin and the source hung on it.
// Assumes the pin is split into input level, output level and enable.
`timescale 1ns/1ps
module ptptc_pin_model (
  // Outside source and device pin
  input  wire logic ext_lvl,
  input  wire logic pin_out,
  input  wire logic pin_oen_n,
  output logic      pin_in
);
  // Device wins while it drives; otherwise the outside source
  assign pin_in = pin_oen_n ? ext_lvl : pin_out;
endmodule : ptptc_pin_model

/* File: tb/ptptc_checker.sv */
// Port-level checks of the trigger/stamp control block.
// Assumes one hclk domain; bound to the top module below.
`timescale 1ns/1ps
module ptptc_checker #(
  parameter int NT = 3,
  parameter int NS = 2
) (
  // Clock, reset and bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Time, pin and interrupt
  input wire logic [31:0] ptp_sec,
  input wire logic [29:0] ptp_ns,
  input wire logic        event_pin_in,
  input wire logic        event_pin_out,
  input wire logic        event_pin_oen_n,
  input wire logic        irq
);
  import ptptc_pkg::*;
  // Address phases taken by the slave
  wire go = hsel && hready && htrans == HTRANS_NONSEQ;
  wire rd_ctrl = go && !hwrite && haddr[11:0] == ADDR_CTRL;
  wire rd_ns = go && !hwrite && haddr[11:0] == ADDR_TGT_NS;
  wire wr_ctrl = go && hwrite && haddr[11:0] == ADDR_CTRL;
  wire wr_ien = go && hwrite && haddr[11:0] == ADDR_IRQ_EN;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_ns_top; rd_ns |=> hrdata[31:30] == 2'h0; endproperty
  a_ns_top: assert property (p_ns_top)
    else $error("ns word top bits set");
  property p_trg_rst; rd_ctrl |=> !hrdata[CTRL_TRG_RST]; endproperty
  a_trg_rst: assert property (p_trg_rst)
    else $error("trigger reset bit reads one");
  property p_ts_rst; rd_ctrl |=> !hrdata[CTRL_TS_RST]; endproperty
  a_ts_rst: assert property (p_ts_rst)
    else $error("stamp reset bit reads one");
  property p_act_en;
    rd_ctrl |=> !hrdata[CTRL_TRG_ACT] || hrdata[CTRL_TRG_EN];
  endproperty
  a_act_en: assert property (p_act_en)
    else $error("active without enable");
  // Pin sampled through two flops, so it must be steady first
  property p_pin_mon;
    $stable(event_pin_in) [*4] ##0 rd_ctrl
      |=> hrdata[CTRL_PIN_IN] == $past(event_pin_in);
  endproperty
  a_pin_mon: assert property (p_pin_mon)
    else $error("pin monitor differs from pin");
  property p_dir_in;
    wr_ctrl ##1 hwdata[CTRL_PIN_DIR] |-> ##[1:2] event_pin_oen_n;
  endproperty
  a_dir_in: assert property (p_dir_in)
    else $error("pin still driven in input mode");
  property p_dir_out;
    wr_ctrl ##1 !hwdata[CTRL_PIN_DIR] |-> ##[1:2] !event_pin_oen_n;
  endproperty
  a_dir_out: assert property (p_dir_out)
    else $error("pin not driven in output mode");
  property p_irq_off;
    wr_ien ##1 hwdata == ZERO32 |-> ##[1:3] !irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("irq high with all enables off");
  property p_pulse; $rose(event_pin_out) |=> !event_pin_out; endproperty
  a_pulse: assert property (p_pulse)
    else $error("trigger pulse longer than one cycle");
endmodule : ptptc_checker

bind ptptc_top ptptc_checker #(.NT(NT), .NS(NS)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .ptp_sec(ptp_sec), .ptp_ns(ptp_ns),
  .event_pin_in(event_pin_in), .event_pin_out(event_pin_out),
  .event_pin_oen_n(event_pin_oen_n), .irq(irq));

/* File: tb/testbench.sv */
// Self-checking bench for the trigger/stamp control block.
// Assumes the pin model beside it and hreadyout fed back as hready.
`timescale 1ns/1ps
module testbench;
  import ptptc_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [31:0] haddr = ZERO32;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = ZERO32;
  logic [31:0] ptp_sec = 32'h0000_0005;
  logic [29:0] ptp_ns = 30'h0000_0000;
  logic        pin_lvl = 1'b0;
  logic [31:0] hrdata, q, t;
  logic        hreadyout, hresp, pin_in, pin_out, pin_oen_n, irq;
  logic [31:0] dl [2];
  int          n_errors = 0;
  int          samples_checked = 0;
  // Clock and a running time count
  always #10 hclk = ~hclk;
  always @(posedge hclk) ptp_ns <= ptp_ns + 30'h0000_0001;
  ptptc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ptp_sec(ptp_sec),
    .ptp_ns(ptp_ns), .event_pin_in(pin_in), .event_pin_out(pin_out),
    .event_pin_oen_n(pin_oen_n), .irq(irq));
  ptptc_pin_model pin (.ext_lvl(pin_lvl), .pin_out(pin_out),
    .pin_oen_n(pin_oen_n), .pin_in(pin_in));
  // One single AHB-Lite transfer; read data lands in q
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    haddr <= {20'h0_0000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, ZERO32);
    chk(q, e);
    chk({31'h0000_0000, hresp}, ZERO32);
  endtask : rdc
  task automatic stop_test();
    $display("compares %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  // Watchdog, far beyond the several hundred cycles the tests need
  initial begin
    repeat (50000) @(posedge hclk);
    n_errors++;
    $display("[ERR] %0t watchdog ran out", $time);
    stop_test();
  end
  // Cascade stays off; single units only
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(ADDR_CTRL, ZERO32);
    rdc(ADDR_TGT_NS, ZERO32);
    rdc(ADDR_TGT_SEC, ZERO32);
    rdc(12'h05fc, ZERO32);
    // Per-unit targets, read back in the reverse order
    for (int u = 0; u < 3; u++) begin
      wr(ADDR_INDEX, 32'(u));
      wr(ADDR_TGT_NS, 32'hffff_fff0 | 32'(u));
      wr(ADDR_TGT_SEC, 32'h1234_0000 | 32'(u));
    end
    for (int u = 2; u >= 0; u--) begin
      wr(ADDR_INDEX, 32'(u));
      rdc(ADDR_TGT_NS, 32'h3fff_fff0 | 32'(u));
      rdc(ADDR_TGT_SEC, 32'h1234_0000 | 32'(u));
    end
    // Fire unit 0 with each output source; flop path is one later
    for (int s = 1; s >= 0; s--) begin
      wr(ADDR_TGT_SEC, ptp_sec);
      t = {2'h0, ptp_ns} + 32'h0000_00c8;
      wr(ADDR_TGT_NS, t);
      wr(ADDR_CTRL, (32'(s) << CTRL_OUT_SEL) | 32'h0000_0008);
      rdc(ADDR_CTRL, (32'(s) << CTRL_OUT_SEL) | 32'h0000_0018);
      for (int n = 0; n < 400 && pin_out !== 1'b1; n++) @(posedge hclk);
      dl[s] = {2'h0, ptp_ns} - t;
      // Let the pulse pass the pin monitor before reading it back
      repeat (4) @(posedge hclk);
      rdc(ADDR_CTRL, 32'(s) << CTRL_OUT_SEL);
    end
    chk(dl[0] - dl[1], 32'h0000_0001);
    wr(ADDR_IRQ_CLR, 32'h0000_001f);
    // Unit 1 armed far ahead: soft reset beats enable, then disable
    wr(ADDR_INDEX, 32'h0000_0001);
    wr(ADDR_TGT_SEC, 32'h0000_0064);
    wr(ADDR_CTRL, 32'h0000_0008);
    rdc(ADDR_CTRL, 32'h0000_0018);
    wr(ADDR_CTRL, 32'h0000_000c);
    rdc(ADDR_CTRL, ZERO32);
    rdc(ADDR_TGT_SEC, ZERO32);
    // Soft reset zeroed the target; restore it so enable does not fire
    wr(ADDR_TGT_SEC, 32'h0000_0064);
    wr(ADDR_CTRL, 32'h0000_0008);
    rdc(ADDR_CTRL, 32'h0000_0018);
    wr(ADDR_CTRL, ZERO32);
    rdc(ADDR_CTRL, ZERO32);
    // Stamp unit 0 in input mode catches a rising pin
    wr(ADDR_IRQ_EN, 32'h0000_0003);
    wr(ADDR_INDEX, ZERO32);
    wr(ADDR_CTRL, 32'h0000_0062);
    pin_lvl <= 1'b1;
    repeat (5) @(posedge hclk);
    rdc(ADDR_CTRL, 32'h0000_00e2);
    rdc(ADDR_IRQ_STAT, 32'h0000_0001);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    pin_lvl <= 1'b0;
    // Mask, then clear
    wr(ADDR_IRQ_EN, ZERO32);
    repeat (3) @(posedge hclk);
    chk({31'h0000_0000, irq}, ZERO32);
    rdc(ADDR_IRQ_STAT, 32'h0000_0001);
    wr(ADDR_IRQ_CLR, 32'h0000_0001);
    wr(ADDR_IRQ_EN, 32'h0000_0003);
    rdc(ADDR_IRQ_STAT, ZERO32);
    // Unit 1 enabled without its interrupt; unit 0 still reports
    wr(ADDR_INDEX, 32'h0000_0100);
    wr(ADDR_CTRL, 32'h0000_0042);
    pin_lvl <= 1'b1;
    repeat (5) @(posedge hclk);
    pin_lvl <= 1'b0;
    repeat (5) @(posedge hclk);
    rdc(ADDR_IRQ_STAT, 32'h0000_0001);
    rdc(ADDR_CTRL, 32'h0000_0042);
    wr(ADDR_INDEX, ZERO32);
    rdc(ADDR_CTRL, 32'h0000_0062);
    wr(ADDR_CTRL, 32'h0000_0063);
    bus(1'b0, ADDR_CTRL, ZERO32);
    chk(q & 32'h0000_0003, ZERO32);
    stop_test();
  end
endmodule : testbench
